/* File: bus_model.sv */
/* CPU/DMA register bus model: one access per call, valid for one clock.
   Assumes one caller at a time, driving just after a rising clock edge. */
`timescale 1ns/1ps
module bus_model (
  input  wire logic                  clock,
  output crc_snoop_pkg::bus_access_t bus
);
  import crc_snoop_pkg::*;
  initial bus = '0;
  // Callers aim the snoop only at serial peripheral registers.
  task automatic access(input logic wr, input logic wd, input logic [13:0] a,
                        input logic [15:0] d);
    @(posedge clock);
    #1;
    bus = '{valid: 1'b1, write: wr, word: wd, addr: a, wdata: wr ? d : ~d, rdata: wr ? ~d : d};
    @(posedge clock);
    #1;
    // A released bus changes every field except the unused one of wdata and rdata, so a latch of old data is caught.
    bus = '{valid: 1'b0, write: ~wr, word: ~wd, addr: ~a, wdata: ~d, rdata: ~d};
  endtask
endmodule // bus_model

/* File: crc_engine_with_bus_snoop.sv */
/*
  Byte-wide CRC engine with a snoop on the CPU/DMA register bus.
  Assumes the bus access struct is valid for exactly one clock per access,
  that software writes arrive as single-cycle strobes, and that word
  accesses are aligned to an even address with the low byte at that address.
*/
`timescale 1ns/1ps
`include "crc_snoop_consts.svh"

module crc_engine_with_bus_snoop (
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire crc_snoop_pkg::poly_sel_t  poly_sel,
  input  wire logic                      seed_we,
  input  wire logic [15:0]               seed_data,
  input  wire logic                      input_we,
  input  wire logic [7:0]                input_data,
  input  wire logic                      target_we,
  input  wire logic [15:0]               target_data,
  input  wire crc_snoop_pkg::bus_access_t bus,
  output logic      [15:0]               crc_result,
  output logic      [7:0]                crc_input_byte,
  output logic      [15:0]               snoop_target_address,
  output logic                           snoop_on_write_enable,
  output logic                           snoop_on_read_enable,
  output logic                           snoop_hit
);
  import crc_snoop_pkg::*;

  // --------------------------------------------------------------------------
  // CRC step
  // --------------------------------------------------------------------------
  // Reference step for the checks below; the datapath uses crc_byte_step.
  function automatic logic [15:0] crc_step(
    input logic [15:0] crc_in,
    input logic [7:0]  data,
    input poly_sel_t   sel
  );
    logic [15:0] c;
    logic [15:0] p;
    c = crc_in ^ {8'h00, data};
    p = (sel == POLY_CRC16) ? `CRC_POLY_16_REFL : `CRC_POLY_CCITT_REFL;
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ p) : (c >> 1);
    end
    return c;
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [7:0]  in_byte_r;
  logic [7:0]  in_byte_nxt;
  logic [15:0] target_r;

  // --------------------------------------------------------------------------
  // Snoop decode
  // --------------------------------------------------------------------------
  wire [13:0] target_addr = target_r[`SNOOP_ADDR_MSB:0];
  wire        wr_en       = target_r[`SNOOP_WR_EN_BIT];
  wire        rd_en       = target_r[`SNOOP_RD_EN_BIT];
  wire        lo_hit      = bus.addr == target_addr;
  wire        hi_hit      = bus.word && ((bus.addr + `BUS_ADDR_STEP) == target_addr);
  wire        dir_en      = bus.write ? wr_en : rd_en;
  wire        hit         = bus.valid && dir_en && (lo_hit || hi_hit);
  wire [15:0] bus_data    = bus.write ? bus.wdata : bus.rdata;
  // A word access hands over only the byte that belongs to the target.
  wire [7:0]  snoop_byte  = lo_hit ? bus_data[`BYTE_LO_MSB:0]
                                   : bus_data[15:`BYTE_HI_LSB];

  // --------------------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------------------
  // A seed in the same cycle comes first, then the snooped byte, then the
  // explicit byte, so nothing that the bus delivered is ever dropped.
  wire [15:0] base_crc    = seed_we ? seed_data : crc_r;
  wire [15:0] snoop_step;
  wire [15:0] input_step;
  wire [15:0] snooped_crc = hit ? snoop_step : base_crc;

  // The snooped byte is folded in first, the explicit byte on top of it.
  crc_byte_step snoop_stepper (
    .crc_in  (base_crc),
    .data    (snoop_byte),
    .sel     (poly_sel),
    .crc_out (snoop_step)
  );

  crc_byte_step input_stepper (
    .crc_in  (snooped_crc),
    .data    (input_data),
    .sel     (poly_sel),
    .crc_out (input_step)
  );

  assign crc_nxt     = input_we ? input_step : snooped_crc;
  assign in_byte_nxt = input_we ? input_data
                     : hit      ? snoop_byte
                                : in_byte_r;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  // The result is updated on the edge that takes the byte: one cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      crc_r     <= `CRC_RESULT_RST;
      in_byte_r <= `CRC_INPUT_RST;
    end else begin
      crc_r     <= crc_nxt;
      in_byte_r <= in_byte_nxt;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      target_r <= `SNOOP_ADDR_RST;
    end else if (target_we) begin
      target_r <= target_data;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign crc_result            = crc_r;
  assign crc_input_byte        = in_byte_r;
  assign snoop_target_address  = target_r;
  assign snoop_on_write_enable = wr_en;
  assign snoop_on_read_enable  = rd_en;
  assign snoop_hit             = hit;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  wire quiet = !seed_we && !input_we && !hit;

  a_poly_ccitt_step: assert property (
    input_we && !seed_we && !hit && poly_sel == POLY_CCITT
    |=> crc_result == crc_step($past(crc_result), $past(input_data), POLY_CCITT))
    else $error("CCITT step gave the wrong result.");

  a_poly_crc16_step: assert property (
    input_we && !seed_we && !hit && poly_sel == POLY_CRC16
    |=> crc_result == crc_step($past(crc_result), $past(input_data), POLY_CRC16))
    else $error("CRC-16 step gave the wrong result.");

  a_known_ccitt: assert property (
    input_we && !seed_we && !hit && poly_sel == POLY_CCITT
    && crc_result == `CRC_KAT_SEED && input_data == `CRC_KAT_BYTE
    |=> crc_result == `CRC_KAT_CCITT)
    else $error("CCITT known answer is wrong.");

  a_known_crc16: assert property (
    input_we && !seed_we && !hit && poly_sel == POLY_CRC16
    && crc_result == `CRC_KAT_SEED && input_data == `CRC_KAT_BYTE
    |=> crc_result == `CRC_KAT_CRC16)
    else $error("CRC-16 known answer is wrong.");

  a_result_holds_idle: assert property (
    quiet |=> $stable(crc_result))
    else $error("Result changed with no byte delivered.");

  a_seed_loads_result: assert property (
    seed_we && !input_we && !hit |=> crc_result == $past(seed_data))
    else $error("Seed did not load the result.");

  a_update_latency: assert property (
    input_we && !seed_we && !hit ##1 quiet [*2]
    |-> crc_result == crc_step($past(crc_result, 2), $past(input_data, 2), $past(poly_sel, 2)))
    else $error("Byte update not finished within two cycles.");

  a_target_store: assert property (
    target_we |=> snoop_target_address == $past(target_data))
    else $error("Snoop target address not stored.");

  a_snoop_gated_off: assert property (
    bus.valid && !input_we && !(bus.write ? snoop_on_write_enable : snoop_on_read_enable)
    |=> $stable(crc_input_byte))
    else $error("Snoop captured a byte while disabled.");

  a_write_snoop_take: assert property (
    bus.valid && bus.write && !bus.word && snoop_on_write_enable && !input_we
    && bus.addr == snoop_target_address[`SNOOP_ADDR_MSB:0]
    |=> crc_input_byte == $past(bus.wdata[`BYTE_LO_MSB:0]))
    else $error("Snooped write byte not captured.");

  a_read_snoop_take: assert property (
    bus.valid && !bus.write && !bus.word && snoop_on_read_enable && !input_we
    && bus.addr == snoop_target_address[`SNOOP_ADDR_MSB:0]
    |=> crc_input_byte == $past(bus.rdata[`BYTE_LO_MSB:0]))
    else $error("Snooped read byte not captured.");

  a_word_high_byte: assert property (
    bus.valid && bus.word && !input_we && snoop_hit
    && bus.addr != snoop_target_address[`SNOOP_ADDR_MSB:0]
    |=> crc_input_byte == $past(bus.write ? bus.wdata[15:`BYTE_HI_LSB]
                                          : bus.rdata[15:`BYTE_HI_LSB]))
    else $error("Word access took the wrong byte.");

  a_snoop_like_write: assert property (
    snoop_hit && !input_we && !seed_we
    |=> crc_result == crc_step($past(crc_result), $past(snoop_byte), $past(poly_sel)))
    else $error("Snooped byte updated the result differently.");

  a_reset_no_snoop: assert property (
    @(posedge clock) disable iff (1'b0)
    !rstn |-> !snoop_on_write_enable && !snoop_on_read_enable)
    else $error("Snoop enabled during reset.");

endmodule // crc_engine_with_bus_snoop

// ----------------------------------------------------------------------------
// One byte through the reflected shift register
// ----------------------------------------------------------------------------
// Unrolled over eight bits so that a whole byte costs one clock; the price is
// a deeper combinational path than a bit-serial shifter would have.
module crc_byte_step (
  input  wire logic [15:0]              crc_in,
  input  wire logic [7:0]               data,
  input  wire crc_snoop_pkg::poly_sel_t sel,
  output logic      [15:0]              crc_out
);
  import crc_snoop_pkg::*;

  wire  [15:0] poly = (sel == POLY_CRC16) ? `CRC_POLY_16_REFL
                                           : `CRC_POLY_CCITT_REFL;
  logic [15:0] acc;

  // Bits enter least significant first, so the polynomials are reflected.
  always_comb begin
    acc = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      acc = acc[0] ? ((acc >> 1) ^ poly) : (acc >> 1);
    end
  end

  assign crc_out = acc;

endmodule // crc_byte_step

/* File: crc_snoop_consts.svh */
/*
  Constants of the CRC engine with bus snoop: bit positions, reset values and
  the reflected generator polynomials. Assumes it is included by bare name.

  //----------------------------------------------------------------------------
  // Summary of operation
  // - Polynomial selectable: CCITT or CRC-16.
  // - Sixteen-bit result, accumulated one byte at a time.
  // - Seed result, then each input byte updates it.
  // - Byte update finishes within two clock cycles.
  // - Snoop target address written by software, compared.
  // - Top two address bits enable read/write snooping.
  // - Enabled write to target captures written byte.
  // - Enabled read of target captures returned byte.
  // - Word access: only the target's byte taken.
  //----------------------------------------------------------------------------
*/
`ifndef CRC_SNOOP_CONSTS_SVH
`define CRC_SNOOP_CONSTS_SVH

`define CRC_POLY_CCITT_REFL 16'h8408
`define CRC_POLY_16_REFL    16'ha001
`define CRC_RESULT_RST      16'h0000
`define CRC_INPUT_RST       8'h00
`define SNOOP_ADDR_RST      16'h0000
`define SNOOP_WR_EN_BIT     15
`define SNOOP_RD_EN_BIT     14
`define SNOOP_ADDR_MSB      13
`define BYTE_LO_MSB         7
`define BYTE_HI_LSB         8
`define BUS_ADDR_STEP       14'h0001
// Known answers: a single 01 byte folded into a zero seed.
`define CRC_KAT_SEED        16'h0000
`define CRC_KAT_BYTE        8'h01
`define CRC_KAT_CCITT       16'h1189
`define CRC_KAT_CRC16       16'hc0c1

`endif

/* File: crc_snoop_pkg.sv */
/*
  Types shared by the CRC engine with bus snoop: the polynomial choice and the
  observed bus access. Assumes the consts header defines nothing it needs.
*/
package crc_snoop_pkg;

  typedef enum logic {
    POLY_CCITT = 1'b0,
    POLY_CRC16 = 1'b1
  } poly_sel_t;

  // One CPU or DMA access seen on the register bus, in the cycle it completes.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [13:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } bus_access_t;

endpackage

/* File: tb_top.sv */
/* Self-checking bench of the CRC engine with bus snoop.
   Assumes the bus model and the design package are compiled first. */
`timescale 1ns/1ps
`include "crc_snoop_consts.svh"
module tb_top;
  import crc_snoop_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b1;
  poly_sel_t   poly_sel = POLY_CCITT;
  logic        seed_we = 1'b0;
  logic        input_we = 1'b0;
  logic        target_we = 1'b0;
  logic [15:0] seed_data = 16'h0000;
  logic [7:0]  input_data = 8'h00;
  logic [15:0] target_data = 16'h0000;
  bus_access_t bus;
  logic [15:0] crc_result;
  logic [15:0] snoop_target_address;
  logic [7:0]  crc_input_byte;
  logic        snoop_on_write_enable;
  logic        snoop_on_read_enable;
  logic        snoop_hit;
  logic [15:0] e;
  int          n_fail = 0;
  int          num_checks = 0;
  always #4 clock = ~clock;
  bus_model bus_m (.clock(clock), .bus(bus));
  crc_engine_with_bus_snoop uut (.clock(clock), .rstn(rstn), .poly_sel(poly_sel),
    .seed_we(seed_we), .seed_data(seed_data), .input_we(input_we),
    .input_data(input_data), .target_we(target_we), .target_data(target_data),
    .bus(bus), .crc_result(crc_result), .crc_input_byte(crc_input_byte),
    .snoop_target_address(snoop_target_address),
    .snoop_on_write_enable(snoop_on_write_enable),
    .snoop_on_read_enable(snoop_on_read_enable), .snoop_hit(snoop_hit));
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] p;
    p = (poly_sel == POLY_CRC16) ? `CRC_POLY_16_REFL : `CRC_POLY_CCITT_REFL;
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ p) : (c >> 1);
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobes {seed, byte, target} for one clock; results show on return.
  task automatic sw(input logic [2:0] we, input logic [15:0] d);
    @(posedge clock);
    #1;
    {seed_we, input_we, target_we} = we;
    {seed_data, input_data, target_data} = {d, d[7:0], d};
    @(posedge clock);
    #1;
    {seed_we, input_we, target_we} = 3'b000;
  endtask
  task automatic snp(input logic wr, wd, input logic [13:0] a, input logic [15:0] d,
                     input logic hit, input logic [7:0] b);
    fork
      bus_m.access(wr, wd, a, d);
      begin
        @(posedge clock);
        #2;
        chk(snoop_hit, hit);
      end
    join
    if (hit) e = step(e, b);
    if (hit) chk(crc_input_byte, b);
    chk(crc_result, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    wrap_up();
  end
  initial begin
    // Drop reset after time zero so that its falling edge is seen.
    #1;
    rstn = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    rstn = 1'b1;
    chk({snoop_on_write_enable, snoop_on_read_enable}, 2'b00);
    chk(crc_result, 16'h0000);
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      poly_sel = poly_sel_t'(s);
      sw(3'b100, `CRC_KAT_SEED);
      sw(3'b010, {8'h00, `CRC_KAT_BYTE});
      chk(crc_result, (poly_sel == POLY_CRC16) ? `CRC_KAT_CRC16 : `CRC_KAT_CCITT);
      e = 16'hffff;
      sw(3'b100, e);
      chk(crc_result, e);
      for (int i = 0; i < 4; i++) begin
        sw(3'b010, 16'h00a5 + 16'(i * 16'h3c));
        e = step(e, 8'(8'ha5 + i * 8'h3c));
        chk(crc_result, e);
      end
    end
    $display("test polynomials done");
    sw(3'b001, 16'h8122);
    chk(snoop_target_address, 16'h8122);
    chk({snoop_on_write_enable, snoop_on_read_enable}, 2'b10);
    snp(1, 0, 14'h0122, 16'h0037, 1, 8'h37);
    snp(0, 0, 14'h0122, 16'h0048, 0, 8'h00);
    snp(1, 0, 14'h0123, 16'h0011, 0, 8'h00);
    sw(3'b001, 16'h4122);
    snp(1, 0, 14'h0122, 16'h0022, 0, 8'h00);
    snp(0, 0, 14'h0122, 16'h0059, 1, 8'h59);
    snp(0, 1, 14'h0122, 16'h9a6b, 1, 8'h6b);
    sw(3'b001, 16'hc123);
    snp(1, 1, 14'h0122, 16'h7c2d, 1, 8'h7c);
    fork
      bus_m.access(1'b1, 1'b0, 14'h0123, 16'h00e1);
      sw(3'b010, 16'h0033);
    join
    e = step(step(e, 8'he1), 8'h33);
    chk(crc_result, e);
    chk(crc_input_byte, 8'h33);
    $display("test snoop done");
    wrap_up();
  end
endmodule // tb_top
